//--- logic/ext_irq_timer.sv
// Purpose: External interrupt inputs and timer count inputs, two channels
// Assumes: Pins synchronous-free sources; mode input from the power manager
// Notes:   Status clears on read; set wins over the clear
`timescale 1ns/1ps
module ext_irq_timer #(
  parameter int unsigned TW = ext_irq_timer_pkg::TIMER_W
) (
  input  wire logic                                   mclk_i,
  input  wire logic                                   rstn_i,
  input  wire logic                                   ext_irq_in_a_i,
  input  wire logic                                   ext_irq_in_b_i,
  input  wire logic                                   count_in_a_i,
  input  wire logic                                   count_in_b_i,
  input  wire logic [1:0]                             pwr_mode_i,
  input  wire logic [ext_irq_timer_pkg::ADDR_W-1:0]   addr_i,
  input  wire logic [ext_irq_timer_pkg::DATA_W-1:0]   wdata_i,
  input  wire logic                                   wr_i,
  input  wire logic                                   rd_i,
  output logic      [ext_irq_timer_pkg::DATA_W-1:0]   rdata_o,
  output logic                                        irq_o,
  output logic                                        wake_o
);

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  pin_sync_if ps ();

  pin_sync u_sync (
    .mclk_i (mclk_i),
    .rstn_i (rstn_i),
    .pins_i ({count_in_b_i, count_in_a_i, ext_irq_in_b_i, ext_irq_in_a_i}),
    .sync   (ps.producer)
  );

  // ---------------------------------------------------------------
  // Register decode
  // ---------------------------------------------------------------
  logic [7:0]    timer_ctrl_reg;
  logic [3:0]    status;
  logic [3:0]    mask;
  logic [1:0]    irq_flag;
  logic [TW-1:0] count_a;
  logic [TW-1:0] count_b;

  wire wr_ctrl = wr_i && (addr_i == ext_irq_timer_pkg::OFS_CTRL);
  wire wr_mask = wr_i && (addr_i == ext_irq_timer_pkg::OFS_MASK);
  wire wr_cnta = wr_i && (addr_i == ext_irq_timer_pkg::OFS_CNT_A);
  wire wr_cntb = wr_i && (addr_i == ext_irq_timer_pkg::OFS_CNT_B);
  wire rd_stat = rd_i && (addr_i == ext_irq_timer_pkg::OFS_STATUS);
  wire rd_flag = rd_i && (addr_i == ext_irq_timer_pkg::OFS_FLAGS);

  wire gate_sel_a = timer_ctrl_reg[ext_irq_timer_pkg::CTL_GATE_A];
  wire gate_sel_b = timer_ctrl_reg[ext_irq_timer_pkg::CTL_GATE_B];
  wire irq_type_a = timer_ctrl_reg[ext_irq_timer_pkg::CTL_TYPE_A];
  wire irq_type_b = timer_ctrl_reg[ext_irq_timer_pkg::CTL_TYPE_B];

  wire pwr_down = (pwr_mode_i == ext_irq_timer_pkg::PWR_DOWN);

  // ---------------------------------------------------------------
  // Interrupt detection (runs in idle and power-down)
  // ---------------------------------------------------------------
  wire det_a = irq_type_a ? ps.fall[0] : ~ps.level[0];
  wire det_b = irq_type_b ? ps.fall[1] : ~ps.level[1];
  wire [1:0] det = {det_b, det_a};

  // ---------------------------------------------------------------
  // Timers
  // ---------------------------------------------------------------
  function automatic logic run_ok(input logic run, input logic gate, input logic pin);
    run_ok = run && (!gate || pin);
  endfunction : run_ok

  function automatic logic step(input logic cnt_mode, input logic fall);
    step = cnt_mode ? fall : 1'b1;
  endfunction : step

  wire en_a = !pwr_down
              && run_ok(timer_ctrl_reg[ext_irq_timer_pkg::CTL_RUN_A], gate_sel_a,
                        ps.level[0])
              && step(timer_ctrl_reg[ext_irq_timer_pkg::CTL_CNT_A], ps.fall[2]);
  wire en_b = !pwr_down
              && run_ok(timer_ctrl_reg[ext_irq_timer_pkg::CTL_RUN_B], gate_sel_b,
                        ps.level[1])
              && step(timer_ctrl_reg[ext_irq_timer_pkg::CTL_CNT_B], ps.fall[3]);

  wire ovf_a = en_a && (&count_a);
  wire ovf_b = en_b && (&count_b);

  wire [3:0] events = {ovf_b, ovf_a, det_b, det_a};

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      count_a <= '0;
    end else if (wr_cnta) begin
      count_a <= wdata_i[TW-1:0];
    end else if (en_a) begin
      count_a <= count_a + 1'b1;
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      count_b <= '0;
    end else if (wr_cntb) begin
      count_b <= wdata_i[TW-1:0];
    end else if (en_b) begin
      count_b <= count_b + 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Control, flags, status
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      timer_ctrl_reg <= ext_irq_timer_pkg::CTRL_RESET;
      mask           <= ext_irq_timer_pkg::MASK_RESET;
    end else begin
      if (wr_ctrl) begin
        timer_ctrl_reg <= wdata_i[7:0];
      end
      if (wr_mask) begin
        mask <= wdata_i[3:0];
      end
    end
  end

  // Channel flags: clear on read of flag register, set wins
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      irq_flag <= 2'h0;
    end else begin
      irq_flag <= (rd_flag ? 2'h0 : irq_flag) | det;
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      status <= 4'h0;
    end else begin
      status <= (rd_stat ? 4'h0 : status) | events;
    end
  end

  // ---------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------
  logic [15:0] next_rdata;

  always_comb begin
    next_rdata = 16'h0000;
    if (rd_i) begin
      case (addr_i)
        ext_irq_timer_pkg::OFS_CTRL:   next_rdata = {8'h00, timer_ctrl_reg};
        ext_irq_timer_pkg::OFS_STATUS: next_rdata = {12'h000, status};
        ext_irq_timer_pkg::OFS_MASK:   next_rdata = {12'h000, mask};
        ext_irq_timer_pkg::OFS_CNT_A:  next_rdata = 16'(count_a);
        ext_irq_timer_pkg::OFS_CNT_B:  next_rdata = 16'(count_b);
        ext_irq_timer_pkg::OFS_FLAGS:  next_rdata = {14'h0000, irq_flag};
        default:                       next_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_o <= 16'h0000;
    end else begin
      rdata_o <= next_rdata;
    end
  end

  // Wake request from external interrupts, also while powered down
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wake_o <= 1'b0;
      irq_o  <= 1'b0;
    end else begin
      wake_o <= |det;
      irq_o  <= |(((rd_stat ? 4'h0 : status) | events) & mask);
    end
  end

endmodule : ext_irq_timer

//--- logic/ext_irq_timer_pkg.sv
// Purpose: Shared constants for the external interrupt and timer input block
// Assumes: 20 MHz system clock, plain register port
// Notes:   Offsets are byte-free word indices on the plain port
package ext_irq_timer_pkg;

  localparam int unsigned ADDR_W       = 4;
  localparam int unsigned DATA_W       = 16;
  localparam int unsigned TIMER_W      = 16;
  localparam int unsigned SYNC_STAGES  = 2;

  // Register offsets
  localparam logic [3:0] OFS_CTRL      = 4'h0;
  localparam logic [3:0] OFS_STATUS    = 4'h1;
  localparam logic [3:0] OFS_MASK      = 4'h2;
  localparam logic [3:0] OFS_CNT_A     = 4'h3;
  localparam logic [3:0] OFS_CNT_B     = 4'h4;
  localparam logic [3:0] OFS_FLAGS     = 4'h5;

  // Control register fields
  localparam int unsigned CTL_RUN_A    = 0;
  localparam int unsigned CTL_RUN_B    = 1;
  localparam int unsigned CTL_GATE_A   = 2;
  localparam int unsigned CTL_GATE_B   = 3;
  localparam int unsigned CTL_CNT_A    = 4;
  localparam int unsigned CTL_CNT_B    = 5;
  localparam int unsigned CTL_TYPE_A   = 6;
  localparam int unsigned CTL_TYPE_B   = 7;
  localparam int unsigned CTL_BITS     = 8;

  // Status and mask fields
  localparam int unsigned ST_IRQ_A     = 0;
  localparam int unsigned ST_IRQ_B     = 1;
  localparam int unsigned ST_OVF_A     = 2;
  localparam int unsigned ST_OVF_B     = 3;
  localparam int unsigned ST_BITS      = 4;

  localparam logic [7:0] CTRL_RESET    = 8'h00;
  localparam logic [3:0] MASK_RESET    = 4'h0;

  typedef enum logic [1:0] {
    PWR_RUN  = 2'b00,
    PWR_IDLE = 2'b01,
    PWR_DOWN = 2'b10
  } pwr_mode_e;

endpackage : ext_irq_timer_pkg

//--- logic/pin_sync.sv
// Purpose: Two-flop synchronisers and falling-edge detect for four pins
// Assumes: Pins idle high
// Notes:   Edge logic looks only at the second stage and beyond
`timescale 1ns/1ps
module pin_sync (
  input  wire logic       mclk_i,
  input  wire logic       rstn_i,
  input  wire logic [3:0] pins_i,
  pin_sync_if.producer    sync
);

  logic [3:0] meta;
  logic [3:0] stable;
  logic [3:0] last;

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta   <= 4'hF;
      stable <= 4'hF;
      last   <= 4'hF;
    end else begin
      meta   <= pins_i;
      stable <= meta;
      last   <= stable;
    end
  end

  assign sync.level = stable;
  assign sync.fall  = last & ~stable;

endmodule : pin_sync

//--- logic/pin_sync_if.sv
// Purpose: Carries synchronised pin levels and falling-edge pulses
// Assumes: One clock domain
// Notes:   Producer is pin_sync, consumer is the top
`timescale 1ns/1ps
interface pin_sync_if;
  logic [3:0] level;
  logic [3:0] fall;
  modport producer (output level, output fall);
  modport consumer (input level, input fall);
endinterface : pin_sync_if

//--- verif/ext_irq_timer_chk.sv
// Purpose: Port-level checks for ext_irq_timer
// Assumes: Read data only in the cycle after a read
// Notes:   Bound into the top module
`timescale 1ns/1ps
module ext_irq_timer_chk (
  input wire logic        mclk_i,
  input wire logic        rstn_i,
  input wire logic        ext_irq_in_a_i,
  input wire logic        ext_irq_in_b_i,
  input wire logic [3:0]  addr_i,
  input wire logic        rd_i,
  input wire logic [15:0] rdata_o,
  input wire logic        wake_o
);
  // ----
  // Checks
  // ----
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);
  sequence rd_at(logic [3:0] a);
    rd_i && addr_i == a;
  endsequence
  sequence wake_soon;
    ##[1:4] wake_o;
  endsequence
  chk_rdata_idle: assert property (!rd_i |=> rdata_o == 16'h0000)
    else $error("read data outside read slot");
  chk_unmapped_zero: assert property (rd_i && addr_i > 4'h5 |=> rdata_o == 16'h0000)
    else $error("unmapped read not zero");
  chk_ctrl_width: assert property (rd_at(4'h0) |=> rdata_o[15:8] == 8'h00)
    else $error("control upper bits set");
  chk_status_width: assert property (rd_at(4'h1) |=> rdata_o[15:4] == 12'h000)
    else $error("status upper bits set");
  chk_flags_width: assert property (rd_at(4'h5) |=> rdata_o[15:2] == 14'h0000)
    else $error("flags upper bits set");
  chk_wake_src: assert property (
    $rose(wake_o) |-> !$past(ext_irq_in_a_i, 3) || !$past(ext_irq_in_b_i, 3))
    else $error("wake without synchronised low pin");
  chk_wake_fall_a: assert property ($fell(ext_irq_in_a_i) |-> wake_soon)
    else $error("no wake after pin a fell");
  chk_wake_fall_b: assert property ($fell(ext_irq_in_b_i) |-> wake_soon)
    else $error("no wake after pin b fell");
endmodule : ext_irq_timer_chk
bind ext_irq_timer ext_irq_timer_chk u_chk (.mclk_i(mclk_i), .rstn_i(rstn_i),
  .ext_irq_in_a_i(ext_irq_in_a_i), .ext_irq_in_b_i(ext_irq_in_b_i), .addr_i(addr_i),
  .rd_i(rd_i), .rdata_o(rdata_o), .wake_o(wake_o));

//--- verif/pin_src.sv
// Purpose: External sources for interrupt and count pins
// Assumes: Pins pulled up, idle high
// Notes:   Index 0 irq a, 1 irq b, 2 count a, 3 count b
`timescale 1ns/1ps
module pin_src (
  input  wire logic       mclk_i,
  output logic      [3:0] pins_o
);
  // ----
  // Drivers
  // ----
  initial pins_o = 4'hF;
  // Three cycles low, three high
  task automatic pulse(input int idx);
    @(posedge mclk_i);
    pins_o[idx] <= 1'b0;
    repeat (3) @(posedge mclk_i);
    pins_o[idx] <= 1'b1;
    repeat (3) @(posedge mclk_i);
  endtask : pulse
  task automatic hold(input int idx, input logic v);
    @(posedge mclk_i);
    pins_o[idx] <= v;
  endtask : hold
endmodule : pin_src

//--- verif/tb_ext_irq_timer.sv
// Purpose: Self-checking bench for ext_irq_timer
// Assumes: Pins from pin_src
// Notes:   Registers reached over the strobe port
`timescale 1ns/1ps
module tb_ext_irq_timer;
  logic        mclk_i     = 1'b0;
  logic        rstn_i     = 1'b0;
  logic [3:0]  pins;
  logic [1:0]  pwr_mode_i = 2'h0;
  logic [3:0]  addr_i     = 4'h0;
  logic [15:0] wdata_i    = 16'h0000;
  logic        wr_i       = 1'b0;
  logic        rd_i       = 1'b0;
  logic [15:0] rdata_o;
  logic        irq_o;
  logic        wake;
  logic [15:0] d;
  int          n_fail     = 0;
  int          cmp_count  = 0;
  int          cyc        = 0;
  // ----
  // Harness
  // ----
  always #25 mclk_i = ~mclk_i;
  pin_src u_pin_src (.mclk_i(mclk_i), .pins_o(pins));
  ext_irq_timer u_ext_irq_timer (.mclk_i(mclk_i), .rstn_i(rstn_i),
    .ext_irq_in_a_i(pins[0]), .ext_irq_in_b_i(pins[1]), .count_in_a_i(pins[2]),
    .count_in_b_i(pins[3]), .pwr_mode_i(pwr_mode_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o), .wake_o(wake));
  task automatic tally_and_finish;
    if (n_fail == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge mclk_i);
    wr_i    <= 1'b1;
    addr_i  <= a;
    wdata_i <= v;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a);
    @(posedge mclk_i);
    rd_i   <= 1'b1;
    addr_i <= a;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask : rd
  task automatic rc(input logic [3:0] a, input logic [15:0] e);
    rd(a);
    chk(d, e);
  endtask : rc
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_fail++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (4) @(posedge mclk_i);
    rstn_i <= 1'b1;
    rc(ext_irq_timer_pkg::OFS_CTRL, 16'h0000);
    rc(ext_irq_timer_pkg::OFS_MASK, 16'h0000);
    wr(4'hF, 16'hFFFF);
    rc(4'hF, 16'h0000);
    wr(ext_irq_timer_pkg::OFS_CTRL, 16'h0033);
    for (int m = 0; m < 3; m++) begin
      @(posedge mclk_i);
      pwr_mode_i <= m[1:0];
      wr(ext_irq_timer_pkg::OFS_CNT_A, 16'h0000);
      wr(ext_irq_timer_pkg::OFS_CNT_B, 16'h0000);
      u_pin_src.pulse(2);
      u_pin_src.pulse(2);
      u_pin_src.pulse(3);
      rc(ext_irq_timer_pkg::OFS_CNT_A, (m == 2) ? 16'h0000 : 16'h0002);
      rc(ext_irq_timer_pkg::OFS_CNT_B, (m == 2) ? 16'h0000 : 16'h0001);
    end
    // Edge mode while powered down
    wr(ext_irq_timer_pkg::OFS_CTRL, 16'h00C0);
    wr(ext_irq_timer_pkg::OFS_MASK, 16'h0001);
    rd(ext_irq_timer_pkg::OFS_STATUS);
    u_pin_src.pulse(0);
    chk({15'h0000, irq_o}, 16'h0001);
    rc(ext_irq_timer_pkg::OFS_FLAGS, 16'h0001);
    rc(ext_irq_timer_pkg::OFS_FLAGS, 16'h0000);
    rc(ext_irq_timer_pkg::OFS_STATUS, 16'h0001);
    @(posedge mclk_i);
    #1 chk({15'h0000, irq_o}, 16'h0000);
    // Level mode, still powered down
    wr(ext_irq_timer_pkg::OFS_CTRL, 16'h0000);
    u_pin_src.hold(1, 1'b0);
    repeat (4) @(posedge mclk_i);
    chk({15'h0000, wake}, 16'h0001);
    rc(ext_irq_timer_pkg::OFS_FLAGS, 16'h0002);
    rc(ext_irq_timer_pkg::OFS_FLAGS, 16'h0002);
    u_pin_src.hold(1, 1'b1);
    repeat (4) @(posedge mclk_i);
    rd(ext_irq_timer_pkg::OFS_FLAGS);
    rc(ext_irq_timer_pkg::OFS_FLAGS, 16'h0000);
    chk({15'h0000, wake}, 16'h0000);
    // Gated timer
    wr(ext_irq_timer_pkg::OFS_CTRL, 16'h0005);
    pwr_mode_i <= 2'h0;
    u_pin_src.hold(0, 1'b0);
    repeat (3) @(posedge mclk_i);
    wr(ext_irq_timer_pkg::OFS_CNT_A, 16'h0000);
    repeat (8) @(posedge mclk_i);
    rc(ext_irq_timer_pkg::OFS_CNT_A, 16'h0000);
    u_pin_src.hold(0, 1'b1);
    repeat (5) @(posedge mclk_i);
    rd(ext_irq_timer_pkg::OFS_CNT_A);
    chk({15'h0000, d != 16'h0000}, 16'h0001);
    // Overflow of timer b in idle
    pwr_mode_i <= 2'h1;
    rd(ext_irq_timer_pkg::OFS_STATUS);
    wr(ext_irq_timer_pkg::OFS_CNT_B, 16'hFFFE);
    wr(ext_irq_timer_pkg::OFS_CTRL, 16'h0002);
    repeat (2) @(posedge mclk_i);
    rc(ext_irq_timer_pkg::OFS_STATUS, 16'h0008);
    rc(ext_irq_timer_pkg::OFS_STATUS, 16'h0000);
    tally_and_finish();
  end
endmodule : tb_ext_irq_timer
